// [bench/serial_nvram_command_unit_test.sv]
// self-checking bench for the serial nvram command unit
`timescale 1ns/1ps
`default_nettype none
module serial_nvram_command_unit_test;
	localparam int STORE_N = 200;
	localparam int PUR_N   = 8;
	logic        clk_sys, reset, store_n_pin, recall_n_pin;
	logic        chip_sel_pin, serial_clock_pin, serial_in_pin;
	logic        serial_out, serial_out_en, store_busy, write_enabled, recall_done;
	logic [15:0] q;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          seed = 32'h7D5EDD13;
	int          busy_n = 0;
	int          ram [16];
	int          nv [16];
	bit          wel, prl;
	snv_unit #(.STORE_CYC(STORE_N), .PUR_CYC(PUR_N)) snv_unit_i (
		.clk_sys(clk_sys), .reset(reset), .chip_sel_pin(chip_sel_pin),
		.serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin),
		.store_n_pin(store_n_pin), .recall_n_pin(recall_n_pin),
		.serial_out(serial_out), .serial_out_en(serial_out_en),
		.store_busy(store_busy), .write_enabled(write_enabled),
		.recall_done(recall_done));
	snv_host snv_host_i (
		.clk_sys(clk_sys), .serial_out(serial_out), .serial_out_en(serial_out_en),
		.chip_sel_pin(chip_sel_pin), .serial_clock_pin(serial_clock_pin),
		.serial_in_pin(serial_in_pin));
	initial begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) if (store_busy === 1'h1) busy_n++;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		end_of_test();
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic done(input string name);
		$display("test %s finished, %0d mismatches so far", name, error_cnt);
	endtask
	function automatic logic [15:0] rnd();
		return 16'($random(seed));
	endfunction
	task automatic cmd(input logic [2:0] op);
		snv_host_i.xfer({1'h1, 4'h0, op, 16'h0}, 8, 1'h0, q);
		if (op == 3'h0) wel = 1'h0;
		if (op == 3'h4) wel = 1'h1;
		if (op == 3'h5) ram = nv;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		snv_host_i.xfer({1'h1, a, 3'h3, d}, 24, 1'h0, q);
		if (wel && prl) ram[a] = d;
	endtask
	task automatic rd(input logic [3:0] a);
		snv_host_i.xfer({1'h1, a, 2'h3, a[0], 16'h0}, 8, 1'h1, q);
		chk("read word", q, ram[a][15:0]);
		chk("output enable", {15'h0, serial_out_en}, 16'h0);
	endtask
	task automatic wait_idle(input bit stored);
		int i;
		for (i = 0; i < 400 && store_busy !== 1'h0; i++) @(negedge clk_sys);
		if (i == 400) begin
			error_cnt++;
			end_of_test();
		end
		repeat (4) @(negedge clk_sys);
		chk("store cycles", busy_n[15:0], stored ? STORE_N[15:0] : 16'h0);
		if (stored) begin
			nv = ram;
			wel = 1'h0;
		end
		chk("latch after store", {15'h0, write_enabled}, {15'h0, wel});
	endtask
	// level request on a hardware pin, released well before the store ends
	task automatic pin(input bit st);
		busy_n = 0;
		if (st) store_n_pin <= 1'h0;
		else recall_n_pin <= 1'h0;
		repeat (10) @(posedge clk_sys);
		store_n_pin <= 1'h1;
		recall_n_pin <= 1'h1;
		repeat (30) @(posedge clk_sys);
		wait_idle(st);
		if (!st) ram = nv;
	endtask
	task automatic do_reset();
		reset <= 1'h1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'h0;
		@(negedge clk_sys);
		chk("flags after reset", {13'h0, write_enabled, recall_done, store_busy}, 16'h0);
		repeat (PUR_N + 30) @(posedge clk_sys);
		chk("flags after power-up", {14'h0, write_enabled, recall_done}, 16'h1);
		foreach (nv[i]) nv[i] = 0;
		ram = nv;
		wel = 1'h0;
		prl = 1'h1;
	endtask
	initial begin
		reset = 1'h1;
		store_n_pin = 1'h1;
		recall_n_pin = 1'h1;
		do_reset();
		done("power-up");
		wr(4'h3, rnd());
		rd(4'h3);
		cmd(3'h4);
		chk("latch set", {15'h0, write_enabled}, 16'h1);
		for (int a = 0; a < 16; a++) wr(a[3:0], rnd());
		snv_host_i.ph = 40;
		rd(4'h0);
		snv_host_i.ph = 6;
		for (int a = 1; a < 16; a++) rd(a[3:0]);
		done("ram access");
		cmd(3'h0);
		chk("latch clear", {15'h0, write_enabled}, 16'h0);
		snv_host_i.xfer({1'h1, 4'h0, 3'h4, 16'h0}, 7, 1'h0, q);
		chk("aborted set", {15'h0, write_enabled}, 16'h0);
		wr(4'h2, rnd());
		rd(4'h2);
		done("abort");
		cmd(3'h4);
		busy_n = 0;
		cmd(3'h1);
		// a set command sent while storing must be ignored
		snv_host_i.xfer({1'h1, 4'h0, 3'h4, 16'h0}, 8, 1'h0, q);
		wait_idle(1'h1);
		busy_n = 0;
		cmd(3'h1);
		wait_idle(1'h0);
		done("store");
		cmd(3'h4);
		wr(4'h5, rnd());
		cmd(3'h5);
		rd(4'h5);
		cmd(3'h4);
		wr(4'h6, rnd());
		pin(1'h0);
		rd(4'h6);
		cmd(3'h4);
		wr(4'h7, rnd());
		pin(1'h1);
		wr(4'h7, rnd());
		cmd(3'h5);
		rd(4'h7);
		done("pins");
		cmd(3'h4);
		do_reset();
		rd(4'h7);
		done("second reset");
		end_of_test();
	end
endmodule
`default_nettype wire

// [bench/snv_host.sv]
// host model that drives the serial command link of the nvram unit
`timescale 1ns/1ps
`default_nettype none
module snv_host (
	input  wire logic clk_sys,
	input  wire logic serial_out,
	input  wire logic serial_out_en,
	output var  logic chip_sel_pin,
	output var  logic serial_clock_pin,
	output var  logic serial_in_pin
);
	// serial clock phase in system cycles; the bench may stretch it to pause the clock
	int ph = 6;
	initial begin
		chip_sel_pin = 1'h0;
		serial_clock_pin = 1'h0;
		serial_in_pin = 1'h0;
	end
	task automatic half();
		repeat (ph) @(posedge clk_sys);
	endtask
	// shifts out n bits of v msb first; rd adds a sixteen-clock read phase
	task automatic xfer(input logic [23:0] v, input int n, input bit rd,
		output logic [15:0] q);
		q = 16'h0;
		chip_sel_pin <= 1'h1;
		half();
		for (int i = 0; i < n; i++) begin
			serial_in_pin <= v[23-i];
			half();
			serial_clock_pin <= 1'h1;
			half();
			serial_clock_pin <= 1'h0;
		end
		for (int i = 0; rd && i < 16; i++) begin
			half();
			q[15-i] = serial_out_en ? serial_out : 1'hX;
			serial_clock_pin <= 1'h1;
			half();
			serial_clock_pin <= 1'h0;
		end
		half();
		chip_sel_pin <= 1'h0;
		// line no longer carries data, so it must not keep the last bit
		serial_in_pin <= ~serial_in_pin;
		half();
	endtask
endmodule
`default_nettype wire

// [logic/snv_defines.svh]
// timing counts, opcodes and reset values of the serial nvram command unit
`ifndef SNV_DEFINES_SVH
`define SNV_DEFINES_SVH
`define SNV_CLK_HZ          40000000
`define SNV_PUR_NS          200
`define SNV_STORE_MS        10
`define SNV_PUR_CYC         (((`SNV_PUR_NS * (`SNV_CLK_HZ / 1000000)) + 999) / 1000)
`define SNV_STORE_CYC       (`SNV_STORE_MS * (`SNV_CLK_HZ / 1000))
`define SNV_RECALL_CYC      16
`define SNV_OP_CLR          3'h0
`define SNV_OP_SAVE         3'h1
`define SNV_OP_WRITE        3'h3
`define SNV_OP_SET          3'h4
`define SNV_OP_RELOAD       3'h5
`define SNV_INSTR_BITS      8
`define SNV_DATA_BITS       16
`define SNV_NV_RESET        16'h0000
`endif

// [logic/snv_fifo.sv]
// small valid/ready fifo for write words
`timescale 1ns/1ps
`default_nettype none
module snv_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	output var  logic [WIDTH-1:0] out_data,
	output var  logic             out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two");
		if (WIDTH < 1) $error("fifo width must be positive");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_r;
	logic [AW:0]      rptr_r;
	wire              full  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
	wire              empty = (wptr_r == rptr_r);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rptr_r[AW-1:0]];
	always_ff @(posedge clk_sys) begin
		if (in_valid && !full) mem[wptr_r[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) wptr_r <= '0;
		else if (in_valid && !full) wptr_r <= wptr_r + 1'b1;
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) rptr_r <= '0;
		else if (out_ready && !empty) rptr_r <= rptr_r + 1'b1;
	end
endmodule
`default_nettype wire

// [logic/snv_pkg.sv]
// types shared by the serial nvram command unit
`default_nettype none
package snv_pkg;
	typedef enum logic [2:0] {
		SNV_POWERUP = 3'h0,
		SNV_IDLE    = 3'h1,
		SNV_RECALL  = 3'h2,
		SNV_STORE   = 3'h3
	} snv_xfer_t;
	typedef enum logic [1:0] {
		SNV_SH_INSTR = 2'h0,
		SNV_SH_WDATA = 2'h1,
		SNV_SH_RDATA = 2'h2,
		SNV_SH_DONE  = 2'h3
	} snv_shift_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [2:0] op;
	} snv_instr_t;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] data;
	} snv_wr_t;
endpackage
`default_nettype wire

// [logic/snv_unit.sv]
// serial command front end and nonvolatile transfer control
`timescale 1ns/1ps
`default_nettype none
`include "snv_defines.svh"
module snv_unit #(
	parameter int STORE_CYC = `SNV_STORE_CYC,
	parameter int PUR_CYC   = `SNV_PUR_CYC
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic chip_sel_pin,
	input  wire logic serial_clock_pin,
	input  wire logic serial_in_pin,
	input  wire logic store_n_pin,
	input  wire logic recall_n_pin,
	output var  logic serial_out,
	output var  logic serial_out_en,
	output var  logic store_busy,
	output var  logic write_enabled,
	output var  logic recall_done
);
	initial begin
		if (STORE_CYC < 1 || PUR_CYC < 1) $error("cycle counts must be positive");
		if (STORE_CYC > 16777215 || PUR_CYC > 16777215) $error("cycle count too large");
	end

	// pins come from the host's domain; two flops before use
	logic [1:0] cs_s_r, sk_s_r, di_s_r, st_s_r, rc_s_r;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cs_s_r <= 2'h0;
			sk_s_r <= 2'h0;
			di_s_r <= 2'h0;
			st_s_r <= 2'h3;
			rc_s_r <= 2'h3;
		end else begin
			cs_s_r <= {cs_s_r[0], chip_sel_pin};
			sk_s_r <= {sk_s_r[0], serial_clock_pin};
			di_s_r <= {di_s_r[0], serial_in_pin};
			st_s_r <= {st_s_r[0], store_n_pin};
			rc_s_r <= {rc_s_r[0], recall_n_pin};
		end
	end
	wire cs = cs_s_r[1];
	wire di = di_s_r[1];
	logic sk_d_r;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) sk_d_r <= 1'b0;
		else sk_d_r <= sk_s_r[1];
	end
	wire sk_rise = sk_s_r[1] && !sk_d_r;
	wire sk_fall = !sk_s_r[1] && sk_d_r;

	// instruction fields as they stand while the eighth bit is on the line
	function automatic logic [2:0] op_now(input logic [7:0] sr, input logic d);
		return {sr[1:0], d};
	endfunction
	function automatic logic [3:0] addr_now(input logic [7:0] sr);
		return sr[5:2];
	endfunction

	logic [15:0]        ram [16];
	logic [15:0]        nv  [16];
	snv_pkg::snv_xfer_t xfer_r;
	snv_pkg::snv_shift_t sh_r;
	logic [23:0]        cnt_r;
	logic [4:0]         rc_idx_r;
	logic [7:0]         isr_r;
	logic [4:0]         nbit_r;
	logic [15:0]        dsr_r;
	snv_pkg::snv_instr_t ins_r;
	logic               wel_r;
	logic               prl_r;
	logic               sw_store_r;
	logic               sw_recall_r;

	wire busy_other = (xfer_r != snv_pkg::SNV_IDLE);
	wire serial_active = cs && (nbit_r != 5'h0 || sh_r != snv_pkg::SNV_SH_INSTR);
	wire hw_store  = !st_s_r[1] && !serial_active;
	wire hw_recall = !rc_s_r[1] && !serial_active;
	wire can_store = wel_r && prl_r;

	// write words queue here so the ram port is shared with recall copies
	snv_pkg::snv_wr_t wq_in, wq_out;
	logic             wq_valid, wq_in_ready, wq_out_valid;
	wire              wq_pop = wq_out_valid && xfer_r == snv_pkg::SNV_IDLE;
	snv_fifo #(.WIDTH(20), .DEPTH(16)) u_wq (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_data   (wq_in),
		.in_valid  (wq_valid),
		.in_ready  (wq_in_ready),
		.out_data  (wq_out),
		.out_valid (wq_out_valid),
		.out_ready (wq_pop)
	);

	// serial shifter: advances only on sampled edges, so a paused clock just waits
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sh_r        <= snv_pkg::SNV_SH_INSTR;
			nbit_r      <= 5'h0;
			isr_r       <= 8'h00;
			dsr_r       <= 16'h0000;
			ins_r       <= '0;
			wq_valid    <= 1'b0;
			wq_in       <= '0;
			sw_store_r  <= 1'b0;
			sw_recall_r <= 1'b0;
		end else begin
			wq_valid <= 1'b0;
			if (xfer_r == snv_pkg::SNV_RECALL) sw_recall_r <= 1'b0;
			if (xfer_r == snv_pkg::SNV_STORE || !can_store) sw_store_r <= 1'b0;
			if (!cs || busy_other) begin
				// deselect drops a partial instruction; busy inhibits the link
				sh_r   <= snv_pkg::SNV_SH_INSTR;
				nbit_r <= 5'h0;
				isr_r  <= 8'h00;
			end else if (sk_rise) begin
				unique case (sh_r)
					snv_pkg::SNV_SH_INSTR: begin
						if (nbit_r != 5'h0 || di) begin
							isr_r  <= {isr_r[6:0], di};
							nbit_r <= nbit_r + 5'h1;
						end
						if (nbit_r == 5'h7) begin
							nbit_r <= 5'h0;
							ins_r.addr <= addr_now(isr_r);
							ins_r.op   <= op_now(isr_r, di);
							unique casez (op_now(isr_r, di))
								3'b11?: begin
									dsr_r <= ram[addr_now(isr_r)];
									sh_r  <= snv_pkg::SNV_SH_RDATA;
								end
								`SNV_OP_WRITE: sh_r <= snv_pkg::SNV_SH_WDATA;
								`SNV_OP_SAVE: begin
									sw_store_r <= can_store;
									sh_r       <= snv_pkg::SNV_SH_DONE;
								end
								`SNV_OP_RELOAD: begin
									sw_recall_r <= 1'b1;
									sh_r        <= snv_pkg::SNV_SH_DONE;
								end
								default: sh_r <= snv_pkg::SNV_SH_DONE;
							endcase
						end
					end
					snv_pkg::SNV_SH_WDATA: begin
						dsr_r  <= {dsr_r[14:0], di};
						nbit_r <= nbit_r + 5'h1;
						if (nbit_r == 5'hF) begin
							sh_r     <= snv_pkg::SNV_SH_DONE;
							wq_in    <= {ins_r.addr, dsr_r[14:0], di};
							wq_valid <= wel_r && prl_r && wq_in_ready;
						end
					end
					snv_pkg::SNV_SH_RDATA: begin
						dsr_r  <= {dsr_r[14:0], 1'b0};
						nbit_r <= nbit_r + 5'h1;
						if (nbit_r == 5'hF) sh_r <= snv_pkg::SNV_SH_DONE;
					end
					snv_pkg::SNV_SH_DONE: ;
				endcase
			end
		end
	end

	// read output: first bit enabled at the falling edge after the eighth clock
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			serial_out    <= 1'b0;
			serial_out_en <= 1'b0;
		end else if (sh_r != snv_pkg::SNV_SH_RDATA || !cs) begin
			serial_out_en <= 1'b0;
			serial_out    <= 1'b0;
		end else if (sk_fall && nbit_r == 5'h0) begin
			serial_out_en <= 1'b1;
			serial_out    <= dsr_r[15];
		end else if (serial_out_en) begin
			serial_out <= dsr_r[15];
		end
	end

	// transfer sequencer: power-up wait, recall copy, timed store
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			xfer_r   <= snv_pkg::SNV_POWERUP;
			cnt_r    <= 24'h000000;
			rc_idx_r <= 5'h00;
		end else begin
			unique case (xfer_r)
				snv_pkg::SNV_POWERUP: begin
					cnt_r <= cnt_r + 24'h1;
					if (cnt_r >= 24'(PUR_CYC - 1)) begin
						xfer_r   <= snv_pkg::SNV_RECALL;
						cnt_r    <= 24'h0;
						rc_idx_r <= 5'h00;
					end
				end
				snv_pkg::SNV_IDLE: begin
					cnt_r <= 24'h0;
					if ((sw_store_r || hw_store) && can_store) begin
						xfer_r <= snv_pkg::SNV_STORE;
					end else if ((sw_recall_r || hw_recall) && !wq_out_valid) begin
						xfer_r   <= snv_pkg::SNV_RECALL;
						rc_idx_r <= 5'h00;
					end
				end
				snv_pkg::SNV_RECALL: begin
					rc_idx_r <= rc_idx_r + 5'h1;
					if (rc_idx_r == 5'hF) xfer_r <= snv_pkg::SNV_IDLE;
				end
				snv_pkg::SNV_STORE: begin
					cnt_r <= cnt_r + 24'h1;
					if (cnt_r >= 24'(STORE_CYC - 1)) xfer_r <= snv_pkg::SNV_IDLE;
				end
				default: xfer_r <= snv_pkg::SNV_IDLE;
			endcase
		end
	end

	// arrays: recall copies a word per cycle, store snapshots all on completion
	always_ff @(posedge clk_sys) begin
		if (xfer_r == snv_pkg::SNV_RECALL) ram[rc_idx_r[3:0]] <= nv[rc_idx_r[3:0]];
		else if (wq_pop) ram[wq_out.addr] <= wq_out.data;
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) nv[i] <= `SNV_NV_RESET;
		end else if (xfer_r == snv_pkg::SNV_STORE && cnt_r >= 24'(STORE_CYC - 1)) begin
			for (int i = 0; i < 16; i++) nv[i] <= ram[i];
		end
	end

	// latches
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wel_r <= 1'b0;
			prl_r <= 1'b0;
		end else begin
			if (xfer_r == snv_pkg::SNV_RECALL && rc_idx_r == 5'hF) prl_r <= 1'b1;
			if (xfer_r == snv_pkg::SNV_STORE && cnt_r >= 24'(STORE_CYC - 1)) begin
				wel_r <= 1'b0;
			end else if (cs && sk_rise && !busy_other && sh_r == snv_pkg::SNV_SH_INSTR
				&& nbit_r == 5'h7) begin
				if (op_now(isr_r, di) == `SNV_OP_SET) wel_r <= 1'b1;
				else if (op_now(isr_r, di) == `SNV_OP_CLR) wel_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			store_busy    <= 1'b0;
			write_enabled <= 1'b0;
			recall_done   <= 1'b0;
		end else begin
			store_busy    <= (xfer_r == snv_pkg::SNV_STORE);
			write_enabled <= wel_r;
			recall_done   <= prl_r;
		end
	end

	// checks on the command path and the transfer sequencer
	chk_out_tristate: assert property (@(posedge clk_sys) disable iff (reset)
		serial_out_en |-> $past(sh_r) == snv_pkg::SNV_SH_RDATA)
		else $error("output driven outside read");
	chk_store_clears: assert property (@(posedge clk_sys) disable iff (reset)
		(xfer_r == snv_pkg::SNV_STORE ##1 xfer_r == snv_pkg::SNV_IDLE) |=> !wel_r)
		else $error("latch still set after store");
	chk_store_needs_latches: assert property (@(posedge clk_sys) disable iff (reset)
		(xfer_r == snv_pkg::SNV_IDLE ##1 xfer_r == snv_pkg::SNV_STORE) |-> $past(can_store))
		else $error("store without latches");
	chk_recall_sets_prl: assert property (@(posedge clk_sys) disable iff (reset)
		(xfer_r == snv_pkg::SNV_RECALL && rc_idx_r == 5'hF) |=> prl_r)
		else $error("recall did not set latch");
	chk_no_write_early: assert property (@(posedge clk_sys) disable iff (reset)
		wq_valid |-> prl_r && wel_r)
		else $error("write accepted without latches");
	chk_store_inhibits: assert property (@(posedge clk_sys) disable iff (reset)
		xfer_r == snv_pkg::SNV_STORE |=> nbit_r == 5'h0 && !serial_out_en)
		else $error("link active during store");
	chk_deselect_clears: assert property (@(posedge clk_sys) disable iff (reset)
		!cs |=> nbit_r == 5'h0 && isr_r == 8'h00)
		else $error("shift register kept after deselect");
	chk_powerup_recall: assert property (@(posedge clk_sys) disable iff (reset)
		(xfer_r == snv_pkg::SNV_POWERUP ##1 xfer_r != snv_pkg::SNV_POWERUP)
		|-> xfer_r == snv_pkg::SNV_RECALL)
		else $error("power-up did not recall");
	chk_write_opcode: assert property (@(posedge clk_sys) disable iff (reset)
		wq_valid |-> ins_r.op == `SNV_OP_WRITE)
		else $error("write queued without write opcode");
	chk_latch_powerup: assert property (@(posedge clk_sys) disable iff (reset)
		xfer_r == snv_pkg::SNV_POWERUP |-> !wel_r)
		else $error("latch set during power-up");
	chk_store_count: assert property (@(posedge clk_sys) disable iff (reset)
		xfer_r == snv_pkg::SNV_STORE |-> cnt_r < 24'(STORE_CYC))
		else $error("store counter past its end");
	chk_pins_wait_link: assert property (@(posedge clk_sys) disable iff (reset)
		(xfer_r == snv_pkg::SNV_IDLE && !sw_store_r && !sw_recall_r
			##1 xfer_r != snv_pkg::SNV_IDLE) |-> $past(!serial_active))
		else $error("pin request taken during an instruction");
	chk_out_quiet_write: assert property (@(posedge clk_sys) disable iff (reset)
		sh_r == snv_pkg::SNV_SH_WDATA |=> !serial_out_en)
		else $error("output driven during write data");

	// main scenarios: store, read, queued write, pin recall, aborted instruction
	cov_store: cover property (@(posedge clk_sys) disable iff (reset)
		xfer_r == snv_pkg::SNV_IDLE ##1 xfer_r == snv_pkg::SNV_STORE);
	cov_read: cover property (@(posedge clk_sys) disable iff (reset) $rose(serial_out_en));
	cov_write: cover property (@(posedge clk_sys) disable iff (reset) wq_pop);
	cov_pin_recall: cover property (@(posedge clk_sys) disable iff (reset)
		xfer_r == snv_pkg::SNV_IDLE && hw_recall ##1 xfer_r == snv_pkg::SNV_RECALL);
	cov_abort: cover property (@(posedge clk_sys) disable iff (reset)
		cs && nbit_r != 5'h0 ##1 !cs);
endmodule
`default_nettype wire
